// ### ptc_ecu.sv
`timescale 1ns/1ps
module ptc_ecu #(
    parameter int FAULT_CYCLES = ptc_pkg::FAULT_CYC,
    parameter int SPLIT_CYCLES = ptc_pkg::DIAG_SPLIT_CYC,
    parameter int FRAME_MIN_CYCLES = ptc_pkg::FRAME_MIN_CYC,
    parameter int FRAME_MAX_CYCLES = ptc_pkg::FRAME_MAX_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    ptc_link_if.ecu link,
    // Decoded frame
    output logic signed [ptc_pkg::TEMPX_W-1:0] temp_dc,
    output logic [ptc_pkg::PRESS_W-1:0] press_mbar,
    output logic [1:0] diag_code,
    output logic diag_valid,
    output logic result_valid,
    // Status
    output logic frame_err,
    output logic line_fault
);
    import ptc_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam int NW = 14;

    if (FAULT_CYCLES < 2 || FAULT_CYCLES >= (1 << CNT_W) - 1
        || SPLIT_CYCLES < 2 || FRAME_MIN_CYCLES > FRAME_MAX_CYCLES) begin : g_chk
        $error("receiver counts out of range");
    end

    logic line_q;
    logic rise;
    logic fall;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] hi_w_q;
    logic [CNT_W-1:0] w_d_q;
    logic [CNT_W-1:0] w_t_q;
    logic [CNT_W-1:0] w_p_q;
    logic [CNT_W-1:0] p_d_q;
    logic [CNT_W-1:0] p_t_q;
    logic [CNT_W-1:0] p_p_q;
    logic [CNT_W:0] frame_sum;
    logic armed_q;
    logic synced_q;
    logic done_q;
    ptc_slot_t slot_q;
    ptc_calc_t calc_q;
    logic [NW-1:0] n_d_q;
    logic [NW-1:0] n_t_q;
    logic [NW-1:0] n_p_q;
    logic signed [TEMPX_W-1:0] temp_v;
    logic [PRESS_W-1:0] press_v;
    logic [1:0] code_v;
    logic code_ok;

    // ********************************
    // Edge detection on the sampled line
    // ********************************
    // Every clock samples the line, so 8 ns resolution on all widths
    assign rise = link.line && !line_q;
    assign fall = !link.line && line_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_q <= 1'b1;
        end else begin
            line_q <= link.line;
        end
    end

    // Cycles since the last rising edge, saturating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (rise) begin
            cnt_q <= CNT_W'(1);
        end else if (cnt_q != CNT_MAX) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // High time of the running slot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_w_q <= '0;
        end else if (fall) begin
            hi_w_q <= cnt_q;
        end
    end

    // ********************************
    // Stuck high detection
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_fault <= 1'b0;
        end else if (!link.line) begin
            line_fault <= 1'b0;
        end else if (cnt_q >= CNT_W'(FAULT_CYCLES)) begin
            line_fault <= 1'b1;
        end
    end

    // ********************************
    // Slot assignment and frame sync
    // ********************************
    // The short slot marks the diagnostic pulse and so the frame start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b0;
            synced_q <= 1'b0;
            done_q <= 1'b0;
            slot_q <= SLOT_DIAG;
            w_d_q <= '0;
            w_t_q <= '0;
            w_p_q <= '0;
            p_d_q <= '0;
            p_t_q <= '0;
            p_p_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (line_fault) begin
                synced_q <= 1'b0;
                armed_q <= 1'b0;
            end else if (rise) begin
                armed_q <= 1'b1;
                if (!armed_q) begin
                    synced_q <= 1'b0;
                end else if (cnt_q < CNT_W'(SPLIT_CYCLES)) begin
                    w_d_q <= hi_w_q;
                    p_d_q <= cnt_q;
                    slot_q <= SLOT_TEMP;
                    synced_q <= 1'b1;
                end else begin
                    case (slot_q)
                        SLOT_TEMP: begin
                            w_t_q <= hi_w_q;
                            p_t_q <= cnt_q;
                            slot_q <= SLOT_PRES;
                        end
                        SLOT_PRES: begin
                            w_p_q <= hi_w_q;
                            p_p_q <= cnt_q;
                            slot_q <= SLOT_DIAG;
                            done_q <= synced_q;
                        end
                        default: begin
                            synced_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    assign frame_sum = (CNT_W+1)'(p_d_q) + (CNT_W+1)'(p_t_q) + (CNT_W+1)'(p_p_q);

    // ********************************
    // Decoding from the normalised widths
    // ********************************
    always_comb begin
        int nt;
        int np;
        int nd;
        int tgt;
        nt = int'(n_t_q);
        np = int'(n_p_q);
        nd = int'(n_d_q);
        tgt = 0;
        code_v = DIAG_OK;
        code_ok = 1'b0;
        if (nt < WIDTH_MIN_US) nt = WIDTH_MIN_US;
        if (nt > WIDTH_MAX_US) nt = WIDTH_MAX_US;
        if (np < WIDTH_MIN_US) np = WIDTH_MIN_US;
        if (np > WIDTH_MAX_US) np = WIDTH_MAX_US;
        temp_v = TEMPX_W'((nt - WIDTH_MIN_US) * TEMP_TENTHS * TEMP_TENTHS / TEMP_US_PER_C_X10
            + TEMP_MIN_C * TEMP_TENTHS);
        press_v = PRESS_W'((np - WIDTH_MIN_US) * MBAR_PER_BAR / PRESS_US_PER_BAR
            + PRESS_MIN_MBAR);
        for (int k = 0; k < DIAG_CODES; k++) begin
            tgt = DIAG_BASE_US + k * DIAG_STEP_US;
            if (nd >= tgt - DIAG_TOL_US && nd <= tgt + DIAG_TOL_US) begin
                code_v = 2'(k);
                code_ok = 1'b1;
            end
        end
    end

    // ********************************
    // Calculation sequence
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            calc_q <= CALC_IDLE;
            frame_err <= 1'b0;
            n_d_q <= '0;
            n_t_q <= '0;
            n_p_q <= '0;
            temp_dc <= '0;
            press_mbar <= '0;
            diag_code <= DIAG_OK;
            diag_valid <= 1'b0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            case (calc_q)
                CALC_IDLE: begin
                    if (done_q) begin
                        if (frame_sum < (CNT_W+1)'(FRAME_MIN_CYCLES)
                            || frame_sum > (CNT_W+1)'(FRAME_MAX_CYCLES)) begin
                            frame_err <= 1'b1;
                        end else begin
                            frame_err <= 1'b0;
                            calc_q <= CALC_NORM;
                        end
                    end
                end
                CALC_NORM: begin
                    n_t_q <= NW'((36'(w_t_q) * 36'(NORM_MEAS_US)) / 36'(p_t_q));
                    n_p_q <= NW'((36'(w_p_q) * 36'(NORM_MEAS_US)) / 36'(p_p_q));
                    n_d_q <= NW'((36'(w_d_q) * 36'(NORM_DIAG_US)) / 36'(p_d_q));
                    calc_q <= CALC_SCALE;
                end
                CALC_SCALE: begin
                    temp_dc <= temp_v;
                    press_mbar <= press_v;
                    diag_code <= code_v;
                    diag_valid <= code_ok;
                    result_valid <= 1'b1;
                    calc_q <= CALC_IDLE;
                end
                default: begin
                    calc_q <= CALC_IDLE;
                end
            endcase
        end
    end
endmodule

// ### ptc_pkg.sv
package ptc_pkg;

    // ********************************
    // Clock and time base
    // ********************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_US = 1000;
    localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

    // ********************************
    // Frame layout in microseconds
    // ********************************
    localparam int FRAME_NOM_US = 9216;
    localparam int SLOT_DIAG_US = 1024;
    localparam int SLOT_MEAS_US = 4096;
    localparam int FRAME_TOL_PCT = 10;
    localparam int WIDTH_MIN_US = 128;
    localparam int WIDTH_MAX_US = 3968;
    localparam int WIDTH_RX_MAX_US = 3958;
    localparam int NORM_DIAG_US = 1024;
    localparam int NORM_MEAS_US = 4096;

    // ********************************
    // Diagnostic code table
    // ********************************
    localparam int DIAG_BASE_US = 256;
    localparam int DIAG_STEP_US = 128;
    localparam int DIAG_TOL_US = 25;
    localparam int DIAG_CODES = 4;
    localparam logic [1:0] DIAG_OK = 2'h0;
    localparam logic [1:0] DIAG_PRESS_FAIL = 2'h1;
    localparam logic [1:0] DIAG_TEMP_FAIL = 2'h2;
    localparam logic [1:0] DIAG_HW_FAIL = 2'h3;

    // ********************************
    // Scaling of the measured values
    // ********************************
    localparam int TEMP_MIN_C = -40;
    localparam int TEMP_MAX_C = 160;
    localparam int TEMP_US_PER_C_X10 = 192;
    localparam int TEMP_OFFSET_US = 896;
    localparam int TEMP_TENTHS = 10;
    localparam int PRESS_MIN_MBAR = 500;
    localparam int PRESS_MAX_MBAR = 10500;
    localparam int PRESS_US_PER_BAR = 384;
    localparam int MBAR_PER_BAR = 1000;

    // ********************************
    // Sample word layout and widths
    // ********************************
    localparam int PRESS_W = 14;
    localparam int TEMP_W = 9;
    localparam int TEMPX_W = 12;
    localparam int SMP_PRESS_LSB = 0;
    localparam int SMP_TEMP_LSB = 14;
    localparam int SMP_DIAG_LSB = 23;
    localparam int SMP_W = 25;
    localparam int SMP_DEPTH = 32;
    localparam logic [SMP_W-1:0] SMP_RESET = 25'h00001F4;
    localparam int US_W = 13;
    localparam int CNT_W = 22;

    // ********************************
    // Receiver cycle counts
    // ********************************
    localparam int DIAG_SPLIT_CYC = (SLOT_DIAG_US + SLOT_MEAS_US) / 2 * CYC_PER_US;
    localparam int FRAME_MIN_CYC = FRAME_NOM_US * CYC_PER_US / 100 * (100 - FRAME_TOL_PCT);
    localparam int FRAME_MAX_CYC = FRAME_NOM_US * CYC_PER_US / 100 * (100 + FRAME_TOL_PCT);
    localparam int FAULT_US = 9216;
    localparam int FAULT_CYC = FAULT_US * CYC_PER_US;

    typedef enum logic [1:0] {
        SLOT_DIAG = 2'h0,
        SLOT_TEMP = 2'h1,
        SLOT_PRES = 2'h3
    } ptc_slot_t;

    typedef enum logic [1:0] {
        CALC_IDLE = 2'h0,
        CALC_NORM = 2'h1,
        CALC_SCALE = 2'h3
    } ptc_calc_t;

endpackage

// ### ptc_link_if.sv
`timescale 1ns/1ps
interface ptc_link_if;
    logic sens_out;
    logic sens_oe;
    logic line;

    // Open collector with pull-up: low only while pulled
    assign line = (sens_oe && !sens_out) ? 1'b0 : 1'b1;

    modport sensor (output sens_out, output sens_oe, input line);
    modport ecu (input line);
endinterface

// ### ptc_sensor.sv
`timescale 1ns/1ps
module ptc_fifo #(
    parameter int W = ptc_pkg::SMP_W,
    parameter int DEPTH = ptc_pkg::SMP_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import ptc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

module ptc_sensor #(
    parameter int DEPTH = ptc_pkg::SMP_DEPTH,
    parameter int TICK_CYC = ptc_pkg::CYC_PER_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    ptc_link_if.sensor link,
    // Samples: diag code, temperature in C, pressure in mbar
    input wire logic [ptc_pkg::SMP_W-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    // Internal hardware fault, stops the pulses
    input wire logic hw_fault
);
    import ptc_pkg::*;

    if (TICK_CYC < 1 || TICK_CYC > 255) begin : g_chk
        $error("tick count out of range");
    end

    logic [SMP_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [SMP_W-1:0] cur_q;
    logic [7:0] tick_q;
    logic [US_W-1:0] us_q;
    logic [US_W-1:0] slot_last;
    logic [US_W-1:0] width;
    ptc_slot_t slot_q;
    logic tick;
    logic slot_end;

    ptc_fifo #(.W(SMP_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_data(sample_data),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ********************************
    // Slot timing, one count per microsecond
    // ********************************
    assign tick = (tick_q == 8'(TICK_CYC - 1));
    assign slot_last = (slot_q == SLOT_DIAG) ? US_W'(SLOT_DIAG_US - 1) : US_W'(SLOT_MEAS_US - 1);
    assign slot_end = tick && (us_q == slot_last);
    assign fifo_pop = slot_end && (slot_q == SLOT_PRES) && fifo_valid && !hw_fault;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_q <= 8'h00;
            us_q <= '0;
            slot_q <= SLOT_DIAG;
        end else if (hw_fault) begin
            tick_q <= 8'h00;
            us_q <= '0;
            slot_q <= SLOT_DIAG;
        end else begin
            tick_q <= tick ? 8'h00 : tick_q + 8'h01;
            if (slot_end) begin
                us_q <= '0;
                case (slot_q)
                    SLOT_DIAG: slot_q <= SLOT_TEMP;
                    SLOT_TEMP: slot_q <= SLOT_PRES;
                    SLOT_PRES: slot_q <= SLOT_DIAG;
                    default: slot_q <= SLOT_DIAG;
                endcase
            end else if (tick) begin
                us_q <= us_q + US_W'(1);
            end
        end
    end

    // Last sample repeats while none is waiting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= SMP_RESET;
        end else if (fifo_pop) begin
            cur_q <= fifo_data;
        end
    end

    // ********************************
    // Pulse width for the running slot
    // ********************************
    always_comb begin
        int t;
        int p;
        int w;
        t = int'($signed(cur_q[SMP_TEMP_LSB +: TEMP_W]));
        p = int'(cur_q[SMP_PRESS_LSB +: PRESS_W]);
        w = 0;
        if (t < TEMP_MIN_C) t = TEMP_MIN_C;
        if (t > TEMP_MAX_C) t = TEMP_MAX_C;
        if (p < PRESS_MIN_MBAR) p = PRESS_MIN_MBAR;
        if (p > PRESS_MAX_MBAR) p = PRESS_MAX_MBAR;
        case (slot_q)
            SLOT_DIAG: w = DIAG_BASE_US + DIAG_STEP_US * int'(cur_q[SMP_DIAG_LSB +: 2]);
            SLOT_TEMP: w = (t * TEMP_US_PER_C_X10) / TEMP_TENTHS + TEMP_OFFSET_US;
            SLOT_PRES: w = WIDTH_MIN_US
                + (p - PRESS_MIN_MBAR) * PRESS_US_PER_BAR / MBAR_PER_BAR;
            default: w = WIDTH_MIN_US;
        endcase
        width = US_W'(w);
    end

    // Released (high) for the pulse, pulled low for the rest of the slot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.sens_oe <= 1'b0;
            link.sens_out <= 1'b0;
        end else begin
            link.sens_oe <= !hw_fault && (us_q >= width);
            link.sens_out <= 1'b0;
        end
    end
endmodule

// ### ptc_link_sva.sv
`timescale 1ns/1ps
module ptc_link_sva #(
    parameter int FAULT_CYCLES = 9216,
    parameter int FRAME_MIN_CYCLES = 8295
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic line,
    input wire logic sens_oe,
    // Sensor and receiver side
    input wire logic hw_fault,
    input wire logic result_valid,
    input wire logic line_fault
);
    int hi_q;
    int lo_q;
    int gap_q;
    logic seen_q;

    // ********
    // Run lengths of the line and result spacing
    // ********
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_q <= 0;
            lo_q <= 0;
        end else begin
            hi_q <= line ? hi_q + 1 : 0;
            lo_q <= line ? 0 : lo_q + 1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= result_valid ? 0 : gap_q + 1;
            seen_q <= seen_q | result_valid;
        end
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_rise;
        !line ##1 line;
    endsequence
    sequence s_stuck;
        hw_fault [*2];
    endsequence

    a_fault_release: assert property (hw_fault |=> !sens_oe)
        else $error("line pulled during a fault");
    a_stuck_high: assert property (s_stuck |-> line)
        else $error("line not high during a fault");
    a_low_width: assert property (s_rise ##0 !$past(hw_fault) |-> lo_q >= 120 && lo_q <= 3976)
        else $error("low part of a slot out of range");
    a_high_width: assert property ($fell(line) |-> hi_q >= 120)
        else $error("pulse shorter than the minimum width");
    a_fault_set: assert property (hi_q >= FAULT_CYCLES + 4 |-> line_fault)
        else $error("stuck high line not flagged");
    a_fault_early: assert property (line_fault && line |-> hi_q >= FAULT_CYCLES - 4)
        else $error("line fault flagged too early");
    a_fault_clear: assert property (line_fault && !line |=> !line_fault)
        else $error("line fault kept while line low");
    a_result_single: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_result_spacing: assert property (result_valid && seen_q |-> gap_q >= FRAME_MIN_CYCLES - 1)
        else $error("two results within one frame");
    a_result_boundary: assert property (result_valid |-> line && hi_q <= 8)
        else $error("result not at a frame boundary");
endmodule

// ### pwm_pressure_temp_frame_codec_tb.sv
`timescale 1ns/1ps
module pwm_pressure_temp_frame_codec_tb;
    import ptc_pkg::*;
    localparam int FLT = 9216;
    localparam int FMIN = 8295;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [SMP_W-1:0] sample_data = '0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    logic hw_fault = 1'b0;
    logic signed [TEMPX_W-1:0] temp_dc;
    logic [PRESS_W-1:0] press_mbar;
    logic [1:0] diag_code;
    logic diag_valid, result_valid, frame_err, line_fault, result_valid_b, frame_err_b;
    logic diag_valid_b;
    logic err_b_q = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    int res_b = 0;
    int rise_b = 0;
    int n;
    logic [31:0] rng = 32'h1783;
    logic [SMP_W-1:0] exp_q[$];

    ptc_link_if link();
    ptc_link_if link_b();
    always #4 clk = ~clk;

    ptc_sensor #(.DEPTH(4), .TICK_CYC(1)) u_ptc_sensor (.clk(clk), .rstn(rstn), .link(link),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .hw_fault(hw_fault));
    ptc_ecu #(.FAULT_CYCLES(FLT), .SPLIT_CYCLES(2560), .FRAME_MIN_CYCLES(FMIN),
        .FRAME_MAX_CYCLES(10137)) u_ptc_ecu (.clk(clk), .rstn(rstn), .link(link),
        .temp_dc(temp_dc), .press_mbar(press_mbar), .diag_code(diag_code),
        .diag_valid(diag_valid), .result_valid(result_valid), .frame_err(frame_err),
        .line_fault(line_fault));
    ptc_ecu #(.FAULT_CYCLES(FLT), .SPLIT_CYCLES(2560), .FRAME_MIN_CYCLES(FMIN),
        .FRAME_MAX_CYCLES(10137)) u_ptc_ecu_b (.clk(clk), .rstn(rstn), .link(link_b),
        .temp_dc(), .press_mbar(), .diag_code(), .diag_valid(diag_valid_b),
        .result_valid(result_valid_b), .frame_err(frame_err_b), .line_fault());
    ptc_link_sva #(.FAULT_CYCLES(FLT), .FRAME_MIN_CYCLES(FMIN)) u_ptc_link_sva (.clk(clk),
        .rstn(rstn), .line(link.line), .sens_oe(link.sens_oe), .hw_fault(hw_fault),
        .result_valid(result_valid), .line_fault(line_fault));

    // ********
    // Helpers
    // ********
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [SMP_W-1:0] word(input logic [1:0] c, input int t, input int p);
        return {c, t[8:0], p[13:0]};
    endfunction

    function automatic logic [SMP_W-1:0] next_word(input logic [1:0] c);
        rng = xs(rng);
        return word(c, -40 + int'(rng % 201), 500 + int'((rng >> 8) % 10001));
    endfunction

    function automatic logic near(input logic signed [31:0] a, input logic signed [31:0] b,
        input int tol);
        logic signed [31:0] d;
        d = a - b;
        return (d >= -tol && d <= tol) === 1'b1;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD at %0t: saw %0h wanted %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic push(input logic [SMP_W-1:0] w);
        sample_data <= w;
        sample_valid <= 1'b1;
        do @(posedge clk); while (sample_ready !== 1'b1);
        exp_q.push_back(w);
    endtask

    task automatic wait_res(input int k);
        repeat (k) begin
            do @(negedge clk); while (result_valid !== 1'b1);
        end
    endtask

    // Far end that stretches or shrinks whole frames
    task automatic slot_b(input int len, input int w);
        link_b.sens_oe <= 1'b0;
        repeat (w) @(posedge clk);
        link_b.sens_oe <= 1'b1;
        repeat (len - w) @(posedge clk);
    endtask

    task automatic drive_b();
        int s[7] = '{100, 100, 120, 100, 89, 100, 100};
        foreach (s[i]) begin
            slot_b(1024 * s[i] / 100, 256);
            slot_b(4096 * s[i] / 100, 896);
            slot_b(4096 * s[i] / 100, 128);
        end
        link_b.sens_oe <= 1'b0;
        $display("frame length test done");
    endtask

    // ********
    // Result monitor
    // ********
    always @(negedge clk) begin
        if (result_valid === 1'b1) begin
            check(32'(near(temp_dc, $signed(exp_q[0][22:14]) * 10, 2)), 32'h1);
            check(32'(near(press_mbar, exp_q[0][13:0], 4)), 32'h1);
            check(32'(diag_code), 32'(exp_q[0][24:23]));
            check(32'(diag_valid), 32'h1);
            check(32'(frame_err), 32'h0);
            if (exp_q.size() > 1)
                exp_q.pop_front();
        end
        if (frame_err_b === 1'b1 && err_b_q !== 1'b1)
            rise_b++;
        err_b_q <= frame_err_b;
        if (result_valid_b === 1'b1)
            res_b++;
    end

    // ********
    // Main sequence
    // ********
    initial begin
        link_b.sens_out = 1'b0;
        link_b.sens_oe = 1'b1;
        repeat (10) @(posedge clk);
        check(32'(link.line), 32'h1);
        rstn <= 1'b1;
        fork
            drive_b();
        join_none
        @(posedge clk);
        push(word(2'h0, -40, 500));
        push(word(2'h1, 160, 10500));
        push(next_word(2'h2));
        push(next_word(2'h3));
        sample_data <= next_word(2'h0);
        @(negedge clk);
        check(32'(sample_ready), 32'h0);
        repeat (3) @(posedge clk);
        sample_valid <= 1'b0;
        $display("fill test done");
        wait_res(1);
        n = 4;
        while (link.line === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check(32'(near(n, 384, 3)), 32'h1);
        wait_res(2);
        @(posedge clk);
        push(next_word(rng[1:0]));
        sample_valid <= 1'b0;
        wait_res(3);
        $display("frame decode test done");
        @(posedge clk);
        hw_fault <= 1'b1;
        n = 0;
        while (line_fault !== 1'b1 && n < 9400) begin
            @(negedge clk);
            n++;
        end
        check(32'(line_fault), 32'h1);
        check(32'(link.line), 32'h1);
        @(posedge clk);
        hw_fault <= 1'b0;
        n = 0;
        while (line_fault !== 1'b0 && n < 800) begin
            @(negedge clk);
            n++;
        end
        check(32'(line_fault), 32'h0);
        $display("fault test done");
        check(32'(res_b), 32'h4);
        check(32'(diag_valid_b), 32'h1);
        check(32'(rise_b), 32'h2);
        check(32'(frame_err_b), 32'h0);
        stop_test();
    end

    initial begin
        #(100000 * 8);
        err_total++;
        $display("BAD at %0t: run did not finish", $time);
        stop_test();
    end
endmodule
